// File: scf_regs.vh
// Register map, field positions, reset values and counts of the sync character framer
`ifndef SCF_REGS_VH
`define SCF_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SCF_OFF_CTRL        8'h00
`define SCF_OFF_STATUS      8'h04
`define SCF_OFF_RXDATA      8'h08
`define SCF_OFF_TXDATA      8'h0C

// ****************************************************************
// Control register fields
// ****************************************************************
`define SCF_CTRL_XMIT_BIT   0
`define SCF_CTRL_RXEN_BIT   1
`define SCF_CTRL_BCC_BIT    2
`define SCF_CTRL_RESET      2'h0

// ****************************************************************
// Status register fields
// ****************************************************************
`define SCF_ST_FIRST_BIT    0
`define SCF_ST_LOCK_BIT     1
`define SCF_ST_FOURTH_BIT   2
`define SCF_ST_RTS_BIT      3
`define SCF_ST_GATE_BIT     4
`define SCF_ST_TXFULL_BIT   5
`define SCF_ST_RXAVAIL_BIT  6
`define SCF_ST_OVR_BIT      7

// ****************************************************************
// Counts
// ****************************************************************
`define SCF_SYNC_COUNT      3'h4

`endif

// File: scf_framer.v
// Synchronous sync-character framer with APB registers and receive FIFO
// Summary of operation
// - Locked only after two successive sync characters
// - While hunting, compare pattern after every bit
// - Second sync checked only on full character
// - Data set timing pulse samples line, stages, shifts
// - Sync match presets all ones plus zero marker
// - First sync flag limits presets to completed characters
// - Next sync locks; otherwise restart the hunt
// - Locked characters move to buffer when it has room
// - Syncs after lock are never passed on
// - Block check clear resets all three sync flags
// - Four device-made syncs precede every transmission
// - Start sets transmit flip-flop and request-to-send
// - Each enabled pulse shifts, drives lowest bit out
// - Start clears counter and requests a sync load
// - Ones fill behind; all ones sends parity, loads
// - Counter counts syncs; after four, load characters
// - Transmit control drop resets the sync counter
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scf_regs.vh"

// ****************************************************************
// Receive character FIFO
// ****************************************************************
module scf_fifo #(
    parameter W     = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW:0]  wptr;
    reg [AW:0]  rptr;
    wire        full;
    wire        empty;

    // Full and empty from pointer wrap bit
    assign empty     = (wptr == rptr);
    assign full      = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rptr[AW-1:0]];

    // Storage write
    always @(posedge pclk) begin
        if (in_valid && !full) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end

    // Pointer update
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr <= {(AW+1){1'b0}};
            rptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wptr <= wptr + 1'b1;
            end
            if (out_ready && !empty) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule

// ****************************************************************
// Framer top
// ****************************************************************
module scf_framer #(
    parameter       CHAR_W     = 8,
    parameter [7:0] SYNC_PAT   = 8'h16,
    parameter       PARITY_ODD = 1,
    parameter       FIFO_DEPTH = 32,
    parameter       FIFO_AW    = 5
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    input  wire        rx_line,
    input  wire        rx_timing,
    input  wire        transmit_bit_pulse,
    input  wire        send_clear_line,
    output wire        send_request_line,
    output reg         tx_line
);
    localparam DW = CHAR_W - 1;

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    reg  [3:0] sync_a;
    reg  [3:0] sync_b;
    reg        rx_tim_d;
    reg        tx_tim_d;
    wire       rx_pulse;
    wire       tx_pulse;
    wire       rx_bit;
    wire       cts;

    // Two flip-flops per pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a   <= 4'hF;
            sync_b   <= 4'hF;
            rx_tim_d <= 1'b1; // Matches the stages, no false edge at release
            tx_tim_d <= 1'b1; // Matches the stages, no false edge at release
        end else begin
            sync_a   <= {send_clear_line, transmit_bit_pulse, rx_timing, rx_line};
            sync_b   <= sync_a;
            rx_tim_d <= sync_b[1];
            tx_tim_d <= sync_b[2];
        end
    end

    assign rx_bit   = sync_b[0];
    assign cts      = sync_b[3];
    assign rx_pulse = sync_b[1] & ~rx_tim_d;
    assign tx_pulse = sync_b[2] & ~tx_tim_d;

    // ****************************************************************
    // Control state
    // ****************************************************************
    reg              transmit_control;
    reg              rx_enable;
    reg              block_check_clear;
    reg              xmit_c_d;
    reg              rx_overrun;
    reg              tx_buf_full;
    reg  [DW-1:0]    tx_buf;
    wire             apb_wr;
    wire             apb_rd;
    wire             tx_start_pulse;
    wire             tx_end_pulse;

    assign apb_wr         = psel & penable & pwrite;
    assign apb_rd         = psel & penable & ~pwrite;
    assign pready         = 1'b1;
    assign tx_start_pulse = transmit_control & ~xmit_c_d;
    assign tx_end_pulse   = ~transmit_control & xmit_c_d;

    // ****************************************************************
    // Receive path
    // ****************************************************************
    reg  [CHAR_W-1:0] rx_shift;
    reg               rx_stage;
    reg               rx_step;
    reg               first_sync_seen;
    reg               sync_locked;
    wire [CHAR_W-1:0] rx_window;
    wire              sync_pattern_match;
    wire              char_complete;
    wire              preset_shift_reg;
    wire              move_to_buffer;
    wire              fifo_in_ready;
    wire              fifo_out_valid;
    wire [CHAR_W-1:0] fifo_out_data;
    wire              rx_pop;

    // Newest bit sits in the staging flip-flop
    assign rx_window          = {rx_stage, rx_shift[CHAR_W-1:1]};
    assign sync_pattern_match = (rx_window == SYNC_PAT[CHAR_W-1:0]);
    assign char_complete      = ~rx_shift[0];

    // Preset on any match while hunting, else only on full characters
    assign preset_shift_reg = rx_step & rx_enable & (
                              (~first_sync_seen & ~sync_locked & sync_pattern_match)
                              | ((first_sync_seen | sync_locked) & char_complete));

    // Completed non-sync characters go to the buffer when it has room
    assign move_to_buffer = rx_step & rx_enable & sync_locked & char_complete
                            & ~sync_pattern_match & fifo_in_ready;
    assign rx_pop         = apb_rd & (paddr == `SCF_OFF_RXDATA);

    // Sample line into staging flip-flop, then into shift register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift <= {CHAR_W{1'b1}};
            rx_stage <= 1'b1;
            rx_step  <= 1'b0;
        end else begin
            rx_step <= rx_pulse;
            if (preset_shift_reg) begin
                rx_shift <= {CHAR_W{1'b1}};
                rx_stage <= 1'b0;
            end else if (rx_pulse) begin
                rx_shift <= {rx_stage, rx_shift[CHAR_W-1:1]};
                rx_stage <= rx_bit;
            end
        end
    end

    // Sync state flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_sync_seen <= 1'b0;
            sync_locked     <= 1'b0;
        end else if (block_check_clear || !rx_enable) begin
            first_sync_seen <= 1'b0;
            sync_locked     <= 1'b0;
        end else if (preset_shift_reg && !sync_locked) begin
            if (!first_sync_seen) begin
                first_sync_seen <= 1'b1;
            end else begin
                first_sync_seen <= 1'b0;
                sync_locked     <= sync_pattern_match;
            end
        end
    end

    // Overrun flag, set wins over write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_overrun <= 1'b0;
        end else if (rx_step && rx_enable && sync_locked && char_complete
                     && !sync_pattern_match && !fifo_in_ready) begin
            rx_overrun <= 1'b1;
        end else if (apb_wr && paddr == `SCF_OFF_STATUS && pwdata[`SCF_ST_OVR_BIT]) begin
            rx_overrun <= 1'b0;
        end
    end

    scf_fifo #(
        .W     (CHAR_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (move_to_buffer),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_window),
        .out_valid (fifo_out_valid),
        .out_ready (rx_pop),
        .out_data  (fifo_out_data)
    );

    // ****************************************************************
    // Transmit path
    // ****************************************************************
    reg  [DW:0]   tx_shift;
    reg           tx_active;
    reg           tx_gate;
    reg           tx_par;
    reg           par_pending;
    reg  [2:0]    sync_cnt;
    wire          fourth_sync_done;
    wire          sync_load_request;
    wire          shift_en;
    wire          parity_insert;
    wire          load_sync_pattern;
    wire          buffer_to_shifter;
    wire          load_next_char;
    wire [DW-1:0] load_data;

    assign send_request_line = tx_active;
    assign fourth_sync_done  = (sync_cnt == `SCF_SYNC_COUNT);
    assign sync_load_request = tx_active & ~fourth_sync_done;
    assign shift_en          = tx_gate & tx_pulse;
    // Empty when all ones apart from the trailing marker zero
    assign parity_insert     = shift_en & (&tx_shift[DW:1]) & ~tx_shift[0];
    assign load_next_char    = parity_insert;
    assign load_sync_pattern = load_next_char & sync_load_request;
    assign buffer_to_shifter = load_next_char & fourth_sync_done & tx_buf_full;
    assign load_data         = load_sync_pattern ? SYNC_PAT[DW-1:0] : tx_buf;

    // Transmit flip-flop and clear-to-send gate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_active <= 1'b0;
            tx_gate   <= 1'b0;
            xmit_c_d  <= 1'b0;
        end else begin
            xmit_c_d <= transmit_control;
            if (tx_start_pulse) begin
                tx_active <= 1'b1;
            end else if (tx_end_pulse) begin
                tx_active <= 1'b0;
            end
            if (!tx_active || !cts) begin
                tx_gate <= 1'b0;
            end else if (tx_pulse) begin
                tx_gate <= 1'b1;
            end
        end
    end

    // Sync counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt <= 3'h0;
        end else if (tx_start_pulse || tx_end_pulse || block_check_clear) begin
            sync_cnt <= 3'h0;
        end else if (load_sync_pattern) begin
            sync_cnt <= sync_cnt + 3'h1;
        end
    end

    // Shift register, ones fill from behind, output flip-flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift    <= {{DW{1'b1}}, 1'b0};
            tx_line     <= 1'b1;
            tx_par      <= 1'b0;
            par_pending <= 1'b0;
        end else if (!tx_active) begin
            tx_shift    <= {{DW{1'b1}}, 1'b0};
            tx_line     <= 1'b1;
            par_pending <= 1'b0;
        end else if (parity_insert) begin
            tx_line <= par_pending ? tx_par : 1'b1;
            if (load_sync_pattern || buffer_to_shifter) begin
                tx_shift    <= {1'b0, load_data};
                tx_par      <= (^load_data) ^ (PARITY_ODD != 0);
                par_pending <= 1'b1;
            end else begin
                par_pending <= 1'b0;
            end
        end else if (shift_en) begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[DW:1]};
        end
    end

    // ****************************************************************
    // APB register slave
    // ****************************************************************
    // Control and transmit holding register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_control  <= 1'b0;
            rx_enable         <= 1'b0;
            block_check_clear <= 1'b0;
            tx_buf_full       <= 1'b0;
            tx_buf            <= {DW{1'b0}};
        end else begin
            block_check_clear <= apb_wr && (paddr == `SCF_OFF_CTRL)
                                 && pwdata[`SCF_CTRL_BCC_BIT];
            if (apb_wr && paddr == `SCF_OFF_CTRL) begin
                transmit_control <= pwdata[`SCF_CTRL_XMIT_BIT];
                rx_enable        <= pwdata[`SCF_CTRL_RXEN_BIT];
            end
            if (buffer_to_shifter) begin
                tx_buf_full <= 1'b0;
            end else if (apb_wr && paddr == `SCF_OFF_TXDATA && !tx_buf_full) begin
                tx_buf      <= pwdata[DW-1:0];
                tx_buf_full <= 1'b1;
            end
        end
    end

    // Read data and error captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            case (paddr)
                `SCF_OFF_CTRL: begin
                    prdata[`SCF_CTRL_XMIT_BIT] <= transmit_control;
                    prdata[`SCF_CTRL_RXEN_BIT] <= rx_enable;
                end
                `SCF_OFF_STATUS: begin
                    prdata[7:0] <= {rx_overrun, fifo_out_valid, tx_buf_full, tx_gate,
                                    tx_active, fourth_sync_done, sync_locked,
                                    first_sync_seen};
                end
                `SCF_OFF_RXDATA: begin
                    prdata[CHAR_W-1:0] <= fifo_out_valid ? fifo_out_data
                                                         : {CHAR_W{1'b0}};
                end
                `SCF_OFF_TXDATA: begin
                    prdata[DW-1:0] <= tx_buf;
                end
                default: begin
                    pslverr <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: scf_framer_properties.sv
// Port-level concurrent checks of the sync character framer, bound to its top
`timescale 1ns/1ps
`default_nettype none
module scf_framer_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_line,
    input wire logic        rx_timing,
    input wire logic        transmit_bit_pulse,
    input wire logic        send_clear_line,
    input wire logic        send_request_line,
    input wire logic        tx_line
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic       ctrl_wr;
    logic       pulse_q;
    logic [3:0] since_pulse;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Control register write at its access edge
    assign ctrl_wr = psel && penable && pwrite && (paddr == 8'h00);

    // Cycles since the last rise of the transmit bit pin, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q <= 1'b0;
            since_pulse <= 4'hF;
        end else begin
            pulse_q <= transmit_bit_pulse;
            if (transmit_bit_pulse && !pulse_q) since_pulse <= 4'h0;
            else if (since_pulse != 4'hF) since_pulse <= since_pulse + 4'h1;
        end
    end

    a_ready_high: assert property (pready)
        else $error("pready low in a cycle");
    a_rts_start: assert property (
        ctrl_wr && pwdata[0] && !send_request_line |-> ##[1:3] send_request_line)
        else $error("request line did not rise after start");
    a_rts_end: assert property (
        ctrl_wr && !pwdata[0] |-> ##[1:3] !send_request_line)
        else $error("request line did not fall at end");
    a_rts_cause: assert property (
        $changed(send_request_line) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
        else $error("request line moved without a control write");
    a_hold_no_cts: assert property (
        (send_request_line && !send_clear_line) [*8] |=> $stable(tx_line))
        else $error("line shifted without clear-to-send");
    a_shift_on_pulse: assert property (
        $fell(tx_line) |-> since_pulse <= 4'h8)
        else $error("line changed away from a bit pulse");
    a_idle_high: assert property (
        !send_request_line [*3] |-> tx_line)
        else $error("line not idle high outside transmission");
    a_err_unmapped: assert property (psel && !penable && paddr > 8'h0F |=> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (
        psel && !penable && paddr <= 8'h0F && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped address");
    a_ctrl_readback: assert property (
        psel && !penable && !pwrite && paddr == 8'h00 |=> prdata[31:2] == 30'h0)
        else $error("control read shows pulse or unused bits");

    c_start: cover property ($rose(send_request_line));
    c_shift: cover property ($fell(tx_line));
    c_error: cover property (psel && penable && pslverr);
endmodule

bind scf_framer scf_framer_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .rx_timing(rx_timing), .transmit_bit_pulse(transmit_bit_pulse),
    .send_clear_line(send_clear_line), .send_request_line(send_request_line),
    .tx_line(tx_line));
`default_nettype wire

// File: scf_dataset_model.sv
// Behavioural synchronous data set: bit timing, clear-to-send and line capture
`timescale 1ns/1ps
`default_nettype none
module scf_dataset_model #(
    parameter int  CTS_NS  = 3000,
    parameter real HALF_NS = 62.5
) (
    output var logic  rx_line,
    output var logic  rx_timing,
    output var logic  transmit_bit_pulse,
    output var logic  send_clear_line,
    input  wire logic send_request_line,
    input  wire logic tx_line
);
    // ****************************************************************
    // Line side
    // ****************************************************************
    logic tx_bits[$];

    // Timing pins start low so reset release shows no false edge
    initial begin
        rx_line = 1'b1;
        rx_timing = 1'b0;
        transmit_bit_pulse = 1'b0;
        send_clear_line = 1'b0;
    end

    // Receive bits LSB first; timing rises mid-bit, then stands still
    task send_bits(input logic [7:0] c, input int n);
        for (int i = 0; i < n; i++) begin
            rx_line = c[i];
            #(HALF_NS) rx_timing = 1'b1;
            #(HALF_NS) rx_timing = 1'b0;
        end
        rx_line = ~rx_line;
    endtask

    // Clear-to-send follows the request after the turn-on delay
    always @(posedge send_request_line) begin
        #(CTS_NS) send_clear_line = send_request_line;
    end
    always @(negedge send_request_line) begin
        #(HALF_NS * 6) send_clear_line = 1'b0;
    end

    // Transmit timing runs around a request; line sampled before each rise
    initial begin
        forever begin
            wait (send_request_line === 1'b1 || send_clear_line === 1'b1);
            #(HALF_NS) tx_bits.push_back(tx_line);
            transmit_bit_pulse = 1'b1;
            #(HALF_NS) transmit_bit_pulse = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: sync_char_framer_test.sv
// Self-checking bench: sync hunt and lock, receive FIFO, transmit sync preamble
`timescale 1ns/1ps
`default_nettype none
`include "scf_regs.vh"
module sync_char_framer_test;
    // ****************************************************************
    // Bench
    // ****************************************************************
    localparam [7:0] SYNC = 8'h16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        rx_line, rx_timing, bit_pulse, clear_line, request_line, tx_line;
    logic [7:0]  paddr, got;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  d0, d1;
    logic [7:0]  exp_q[$];
    integer      seed, bad_count, tests_run, i, n, k, r;

    scf_framer #(.SYNC_PAT(SYNC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line(rx_line), .rx_timing(rx_timing), .transmit_bit_pulse(bit_pulse),
        .send_clear_line(clear_line), .send_request_line(request_line), .tx_line(tx_line));
    scf_dataset_model #(.CTS_NS(3000)) dm (
        .rx_line(rx_line), .rx_timing(rx_timing), .transmit_bit_pulse(bit_pulse),
        .send_clear_line(clear_line), .send_request_line(request_line), .tx_line(tx_line));

    // Free-running 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run = tests_run + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task final_report();
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A spent wait bound counts as a mismatch and closes the run
    task hang();
        bad_count = bad_count + 1;
        final_report();
    endtask

    // One APB transfer; result taken at the edge that sees pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t = t + 1;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Character as it appears on the line: 7 data bits then odd parity
    function automatic logic [7:0] line_char(input logic [6:0] d);
        return {~^d, d};
    endfunction

    function automatic logic [7:0] rnd_char();
        logic [7:0] v;
        v = 8'($random(seed));
        if (v == SYNC) v = 8'h55;
        return v;
    endfunction

    // Main sequence
    initial begin
        seed = 32'h467E7DB7;
        bad_count = 0;
        tests_run = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `SCF_OFF_CTRL, 32'h2);
        dm.send_bits(8'hFF, 1 + {$random(seed)} % 7);
        dm.send_bits(SYNC, 8);
        apb(1'b0, `SCF_OFF_STATUS, 32'h0);
        chk(rd[1:0], 2'h1);
        dm.send_bits(8'hFF, 8);
        apb(1'b0, `SCF_OFF_STATUS, 32'h0);
        chk(rd[1:0], 2'h0);
        dm.send_bits(SYNC, 8);
        dm.send_bits(SYNC, 8);
        apb(1'b0, `SCF_OFF_STATUS, 32'h0);
        chk(rd[1:0], 2'h2);
        for (i = 0; i < 34; i++) begin
            got = rnd_char();
            if (i == 5) got = SYNC;
            else if (exp_q.size() < 32) exp_q.push_back(got);
            dm.send_bits(got, 8);
        end
        apb(1'b0, `SCF_OFF_STATUS, 32'h0);
        chk(rd[7:6], 2'h3);
        for (i = 0; i < 33; i++) begin
            apb(1'b0, `SCF_OFF_RXDATA, 32'h0);
            chk(rd, (i < 32) ? {24'h0, exp_q[i]} : 32'h0);
        end
        apb(1'b1, `SCF_OFF_STATUS, 32'h80);
        apb(1'b1, `SCF_OFF_CTRL, 32'h6);
        apb(1'b0, `SCF_OFF_STATUS, 32'h0);
        chk(rd[7:0], 8'h0);
        apb(1'b0, `SCF_OFF_CTRL, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        for (r = 0; r < 2; r++) begin
            dm.tx_bits.delete();
            d0 = 7'($random(seed));
            d1 = 7'($random(seed));
            apb(1'b1, `SCF_OFF_TXDATA, {25'h0, d0});
            apb(1'b1, `SCF_OFF_CTRL, 32'h3);
            n = 0;
            do begin
                apb(1'b0, `SCF_OFF_STATUS, 32'h0);
                n = n + 1;
            end while (rd[5] !== 1'b0 && n < 5000);
            if (n >= 5000) hang();
            chk(rd[4:2], 3'h7);
            apb(1'b1, `SCF_OFF_TXDATA, {25'h0, d1});
            n = 0;
            while (dm.tx_bits.size() < 90 && n < 20000) begin
                @(posedge pclk);
                n = n + 1;
            end
            if (n >= 20000) hang();
            apb(1'b1, `SCF_OFF_CTRL, 32'h2);
            k = 0;
            while (k < 40 && dm.tx_bits[k] === 1'b1) k++;
            for (i = 0; i < 6; i++) begin
                for (n = 0; n < 8; n++) got[n] = dm.tx_bits[k + 8 * i + n];
                chk(got, line_char(i == 4 ? d0 : (i == 5 ? d1 : SYNC[6:0])));
            end
            repeat (200) @(posedge pclk);
            apb(1'b0, `SCF_OFF_STATUS, 32'h0);
            chk(rd[3:2], 2'h0);
        end
        final_report();
    end
endmodule
`default_nettype wire
